// ==== tb_vcr_cap_regs.sv ====
/*
 * Self-checking bench for the capability register bank and entry check.
 * Assumes vcr_defs.svh and vcr_pkg on the include path; no checker file.
 */
`timescale 1ns/1ps
`include "vcr_defs.svh"

module tb_vcr_cap_regs
    import vcr_pkg::*;
;
    // ****************************************
    // Stimulus tables
    // ****************************************
    typedef struct packed {
        logic [11:0] idx;
        logic wr;
        logic [63:0] d1;
        logic f1;
        logic [63:0] d2;
        logic f2;
    } vcr_acc_row_t;
    localparam logic [63:0] BASIC1 = 64'h00d8_1000_0000_0001;
    localparam logic [63:0] BASIC2 = 64'h0040_1000_0000_0001;
    localparam logic [63:0] PIN = 64'h0000_00ff_0000_0016;
    localparam vcr_acc_row_t ACC[8] = '{
        '{12'h480, 1'b0, BASIC1, 1'b0, BASIC2, 1'b0},
        '{12'h481, 1'b0, PIN, 1'b0, PIN, 1'b0},
        '{12'h48d, 1'b0, 64'h0000_00ff_0000_0000, 1'b0, 64'h0, 1'b1},
        '{12'h480, 1'b1, 64'h0, 1'b1, 64'h0, 1'b1},
        '{12'h481, 1'b1, 64'h0, 1'b1, 64'h0, 1'b1},
        '{12'h48d, 1'b1, 64'h0, 1'b1, 64'h0, 1'b1},
        '{12'h482, 1'b0, 64'h0, 1'b1, 64'h0, 1'b1},
        '{12'h47f, 1'b0, 64'h0, 1'b1, 64'h0, 1'b1}};
    // Control vector, then expected fail with and without flexible defaults.
    localparam logic [33:0] ENT[6] = '{
        {32'h0000_0016, 2'b00}, {32'h0000_0000, 2'b01},
        {32'h0000_0014, 2'b01}, {32'h0000_00ff, 2'b00},
        {32'h0000_0116, 2'b11}, {32'h8000_0016, 2'b11}};

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic entryReq = 1'b0;
    logic [31:0] pinControls = 32'h0;
    vcr_req_t req = '0;
    vcr_rsp_t rsp1, rsp2;
    logic done1, done2, fail1, fail2;
    logic [3:0] mem1, mem2;
    int failCount = 0;
    int samplesChecked = 0;

    // The bank under test, and a second one with fixed defaults and an
    // uncacheable structure type, so that the reported type visibly moves.
    vcr_cap_regs uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .req(req), .rsp(rsp1),
        .entryReq(entryReq), .pinControls(pinControls), .entryDone(done1),
        .entryFail(fail1), .structMemType(mem1));
    vcr_cap_regs #(.FLEX_DEFAULTS(1'b0), .MEM_TYPE(`VCR_MEM_UNCACHEABLE)) uutFixed (
        .clk(clk), .reset_n(reset_n),
        .clkEn(clkEn), .req(req), .rsp(rsp2), .entryReq(entryReq),
        .pinControls(pinControls), .entryDone(done2), .entryFail(fail2),
        .structMemType(mem2));

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    // ****************************************
    // Compare and access tasks
    // ****************************************
    task automatic chkWord(input string name, input logic [63:0] exp, input logic [63:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chkWord

    task automatic chkRsp(input vcr_rsp_t r, input logic [63:0] d, input logic f);
        chkWord("rspValid", 64'(1'b1), 64'(r.valid));
        chkWord("rspFault", 64'(f), 64'(r.fault));
        chkWord("rspErrorCode", 64'h0, 64'(r.errorCode));
        chkWord("rspData", d, r.data);
    endtask : chkRsp

    // Drives one access at a falling edge; the caller releases the strobe.
    task automatic acc(input vcr_acc_row_t r);
        req = '{1'b1, r.wr, r.idx};
        @(negedge clk);
        chkRsp(rsp1, r.d1, r.f1);
        chkRsp(rsp2, r.d2, r.f2);
    endtask : acc

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // A hang is cut short here and counted as a mismatch.
    initial
    begin
        #50000;
        failCount++;
        close_out();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (10) @(negedge clk);
        chkWord("rspValidReset", 64'h0, 64'(rsp1.valid));
        chkWord("memTypeReset", 64'h6, 64'(mem1));
        chkWord("memTypeResetFixed", 64'h6, 64'(mem2));
        reset_n = 1'b1;
        @(negedge clk);
        // Back-to-back accesses straight through the table.
        foreach (ACC[i])
            acc(ACC[i]);
        req = '0;
        foreach (ENT[i])
        begin
            entryReq = 1'b1;
            pinControls = ENT[i][33:2];
            @(negedge clk);
            chkWord("entryDone", 64'h3, 64'({done1, done2}));
            chkWord("entryFail", 64'(ENT[i][1]), 64'(fail1));
            chkWord("entryFailFixed", 64'(ENT[i][0]), 64'(fail2));
        end
        entryReq = 1'b0;
        @(negedge clk);
        chkWord("entryDoneIdle", 64'h0, 64'({done1, fail1}));
        chkWord("memType", 64'h6, 64'(mem1));
        chkWord("memTypeFixed", 64'h0, 64'(mem2));
        // A request with the clock enable low must not be answered.
        clkEn = 1'b0;
        req = '{1'b1, 1'b0, 12'h480};
        repeat (3)
        begin
            @(negedge clk);
            chkWord("rspHeld", 64'h0, 64'(rsp1.valid));
        end
        clkEn = 1'b1;
        acc(ACC[0]);
        req = '0;
        @(negedge clk);
        chkWord("rspPulse", 64'h0, 64'(rsp1.valid));
        // Reset in mid-answer clears the response at once.
        acc(ACC[1]);
        req = '0;
        reset_n = 1'b0;
        #1;
        chkWord("rspMidReset", 64'h0, rsp1.data);
        chkWord("rspMidResetFlags", 64'h0, 64'({rsp1.valid, rsp1.fault, rsp1.errorCode}));
        chkWord("rspMidResetFixed", 64'h0, rsp2.data);
        chkWord("memTypeMidReset", 64'h6, 64'(mem2));
        @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        acc(ACC[3]);
        req = '0;
        @(negedge clk);
        chkWord("memTypeAfterReset", 64'h0, 64'(mem2));
        close_out();
    end
endmodule : tb_vcr_cap_regs

// ==== vcr_cap_regs.sv ====
/*
 * Read-only bank of virtualization capability registers with the pin
 * control entry check. Accessed by indexed register read and write.
 * Assumes requests from same-clock logic, one outstanding at a time.
 */
`timescale 1ns/1ps
`include "vcr_defs.svh"

module vcr_cap_regs
    import vcr_pkg::*;
#(
    parameter logic [30:0] REVISION_ID = 31'h0000_0001, // Arbitrary value.
    parameter logic [12:0] REGION_BYTES = 13'h1000,
    parameter logic DUAL_MONITOR = 1'b0,
    parameter logic STRING_IO_INFO = 1'b1,
    parameter logic FLEX_DEFAULTS = 1'b1,
    parameter logic [3:0] MEM_TYPE = `VCR_MEM_WRITE_BACK,
    parameter logic [31:0] PIN_ALLOW0 = 32'h0000_0016,
    parameter logic [31:0] PIN_ALLOW1 = 32'h0000_00ff,
    parameter logic [31:0] PIN_TRUE_ALLOW0 = 32'h0000_0000
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Register access
    input wire vcr_req_t req,
    output vcr_rsp_t rsp,
    // Entry check
    input wire logic entryReq,
    input wire logic [31:0] pinControls,
    output logic entryDone,
    output logic entryFail,
    // Memory type the device uses for its own structure accesses
    output logic [3:0] structMemType
);

    // ****************************************
    // Register images
    // ****************************************

    // The size field is clamped and bit 44 is derived so it can never
    // disagree with the lower twelve bits.
    logic [12:0] sizeField;
    logic [3:0] memField;
    logic [63:0] basicWord;
    logic [63:0] pinWord;
    logic [63:0] pinTrueWord;
    logic [63:0] checkWord;
    logic [63:0] readData;
    logic hitBasic;
    logic hitPin;
    logic hitTrue;
    logic mapped;
    logic rawFail;

    assign sizeField = (REGION_BYTES == 13'h0 || REGION_BYTES > `VCR_SIZE_MAX) ?
                       `VCR_SIZE_MAX : REGION_BYTES;
    assign memField = (MEM_TYPE == `VCR_MEM_UNCACHEABLE) ?
                      `VCR_MEM_UNCACHEABLE : `VCR_MEM_WRITE_BACK;
    assign basicWord = {8'h00,
                        FLEX_DEFAULTS,
                        STRING_IO_INFO,
                        memField,
                        DUAL_MONITOR,
                        1'b0,
                        3'h0,
                        sizeField,
                        1'b0, REVISION_ID};
    // Default-one bits are forced so a careless parameter cannot clear them.
    assign pinWord = {PIN_ALLOW1, PIN_ALLOW0 | `VCR_DEFAULT_ONE_MASK};
    assign pinTrueWord = {PIN_ALLOW1, PIN_TRUE_ALLOW0};

    // Address decode; the true register exists only when bit 55 is one.
    assign hitBasic = req.index == `VCR_IDX_BASIC;
    assign hitPin = req.index == `VCR_IDX_PIN;
    assign hitTrue = (req.index == `VCR_IDX_PIN_TRUE) && FLEX_DEFAULTS;
    assign mapped = hitBasic | hitPin | hitTrue;
    assign readData = hitBasic ? basicWord :
                      hitPin ? pinWord :
                      hitTrue ? pinTrueWord : 64'h0;

    // Without bit 55 the plain register carries the default-one bits as
    // must-be-one, which is exactly the reserved-at-one behaviour.
    assign checkWord = basicWord[`VCR_BIT_FLEX] ? pinTrueWord : pinWord;

    vcr_entry_check #(
        .WIDTH(32)
    ) u_check (
        .controls(pinControls),
        .capWord(checkWord),
        .fail(rawFail)
    );

    // ****************************************
    // Register answer and entry result
    // ****************************************

    // Answers come one cycle after the request; writes and unmapped
    // indices fault with error code zero and change nothing.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp <= '0;
        end
        else if (clkEn)
        begin
            rsp.valid <= req.valid;
            rsp.fault <= req.valid & (req.write | ~mapped);
            rsp.errorCode <= `VCR_GP_ERROR_CODE;
            rsp.data <= (req.valid & ~req.write & mapped) ? readData : 64'h0;
        end
    end

    // Entry result registered one cycle after the request.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            entryDone <= 1'b0;
            entryFail <= 1'b0;
        end
        else if (clkEn)
        begin
            entryDone <= entryReq;
            entryFail <= entryReq & rawFail;
        end
    end

    // The device's own structure accesses use the reported type from the first enabled clock after reset, which loads write-back.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            structMemType <= `VCR_MEM_WRITE_BACK;
        end
        else if (clkEn)
        begin
            structMemType <= memField;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_writeReq;
        clkEn && req.valid && req.write;
    endsequence

    chk_write_faults: assert property (s_writeReq |=> rsp.valid && rsp.fault
        && rsp.errorCode == 16'h0000) else $error("Write did not fault.");
    chk_basic_reserved: assert property (clkEn && req.valid && !req.write
        && req.index == 12'h480 |=> rsp.data[63:56] == 8'h00
        && rsp.data[47:45] == 3'h0 && !rsp.data[31]) else $error("Reserved bit set.");
    chk_size_range: assert property (clkEn && req.valid && !req.write
        && req.index == 12'h480 |=> rsp.data[44] == (rsp.data[43:32] == 12'h0))
        else $error("Size field inconsistent.");
    chk_mem_type: assert property (clkEn && req.valid && !req.write
        && req.index == 12'h480 |=> rsp.data[53:50] == 4'h0 || rsp.data[53:50] == 4'h6)
        else $error("Bad memory type.");
    chk_addr_width: assert property (clkEn && req.valid && !req.write
        && req.index == 12'h480 |=> !rsp.data[48]) else $error("Address width bit set.");
    chk_default_one: assert property (clkEn && req.valid && !req.write
        && req.index == 12'h481 |=> rsp.data[4] && rsp.data[2] && rsp.data[1])
        else $error("Default-one bit clear.");
    chk_fail_allow1: assert property (clkEn && entryReq
        && |(pinControls & ~checkWord[63:32]) |=> entryDone && entryFail)
        else $error("Allowed-1 violation missed.");
    chk_fail_allow0: assert property (clkEn && entryReq
        && |(~pinControls & checkWord[31:0]) |=> entryFail)
        else $error("Allowed-0 violation missed.");
    chk_pass_clean: assert property (clkEn && entryReq
        && !(|(pinControls & ~checkWord[63:32])) && !(|(~pinControls & checkWord[31:0]))
        |=> entryDone && !entryFail) else $error("Clean vector failed.");
    chk_true_absent: assert property (clkEn && req.valid && !req.write
        && req.index == 12'h48d && !FLEX_DEFAULTS |=> rsp.fault)
        else $error("True register present without bit 55.");
    chk_strict_ones: assert property (clkEn && entryReq && !FLEX_DEFAULTS
        && (pinControls & 32'h16) != 32'h16 |=> entryFail)
        else $error("Default-one zero accepted.");
    chk_mem_used: assert property (clkEn |=> structMemType == $past(memField))
        else $error("Structure memory type drifted.");

endmodule : vcr_cap_regs

// ==== vcr_defs.svh ====
/*
 * Constants for the virtualization capability register bank: register
 * indices, field positions and fixed field values.
 * Assumes inclusion by bare name from the package and the design files.
 */
// Notes on behaviour
// - Low 31 bits revision, bit 31 zero
// - Bits 44:32 region size, 1..4096 bytes
// - Bit 48 address width, zero here
// - Bit 49 set only with dual-monitor support
// - Bits 53:50 memory type, 0 or 6
// - Bit 54 gates string I/O exit info
// - Bit 55 flexible defaults, true register exists
// - Reserved basic bits read zero
// - Bit 55 zero: default-one controls must be one
// - Index 481H low half: allowed 0-settings
// - Controls 1, 2, 4 read one there
// - High half: allowed 1-settings, checked
// - Index 48DH true register when bit 55
// - Device keeps reported memory type internally, write-back from reset to first enabled clock
// - Writes fault with error code zero
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH

// ****************************************
// Register indices
// ****************************************
`define VCR_IDX_BASIC 12'h480
`define VCR_IDX_PIN 12'h481
`define VCR_IDX_PIN_TRUE 12'h48d

// ****************************************
// Field positions and values
// ****************************************
`define VCR_SIZE_MAX 13'h1000
`define VCR_MEM_UNCACHEABLE 4'h0
`define VCR_MEM_WRITE_BACK 4'h6
`define VCR_DEFAULT_ONE_MASK 32'h0000_0016
`define VCR_GP_ERROR_CODE 16'h0000
`define VCR_BIT_FLEX 55

`endif

// ==== vcr_entry_check.sv ====
/*
 * Entry check on the pin control vector against the allowed settings.
 * Assumes a capability word already chosen for the current bit 55 setting.
 */
`timescale 1ns/1ps
`include "vcr_defs.svh"

module vcr_entry_check
    import vcr_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    // Control vector and capability word
    input wire logic [WIDTH-1:0] controls,
    input wire logic [2*WIDTH-1:0] capWord,
    // Result
    output logic fail
);

    logic [WIDTH-1:0] bitFail;

    // Each bit fails when it is zero but must be one, or one but may not be.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            assign bitFail[gi] = (capWord[gi] & ~controls[gi])
                               | (~capWord[WIDTH+gi] & controls[gi]);
        end
    endgenerate

    assign fail = |bitFail;

endmodule : vcr_entry_check

// ==== vcr_pkg.sv ====
/*
 * Types for the virtualization capability register bank.
 * Assumes vcr_defs.svh is on the include path.
 */
`include "vcr_defs.svh"

package vcr_pkg;

    // ****************************************
    // Register access and answer carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] index;
    } vcr_req_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [15:0] errorCode;
        logic [63:0] data;
    } vcr_rsp_t;

    // Register read sequencer states, Gray coded.
    typedef enum logic [1:0] {
        VCR_IDLE = 2'b00,
        VCR_ANSWER = 2'b01
    } vcr_state_t;

endpackage : vcr_pkg
